// *** core/tws_pkg.sv ***
// Shared constants and types for the two-wire slave with power-fail lockout
package tws_pkg;

  // ----------------------------------------------------------------
  // Addressing and storage
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h68; // Write form 1101_0000
  localparam int MEM_BYTES = 64;             // Clock registers plus RAM
  localparam int PTR_W = 6;                  // Byte pointer width
  localparam logic [5:0] PTR_RST = 6'h00;    // Pointer after reset
  localparam logic [5:0] PTR_STEP = 6'h01;   // Pointer increment

  // ----------------------------------------------------------------
  // Bit counter positions within one nine-clock byte slot
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_FIRST = 4'h0;   // First data bit
  localparam logic [3:0] BIT_LAST = 4'h7;    // Eighth data bit
  localparam logic [3:0] BIT_ACK = 4'h8;     // Acknowledge slot

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic LINE_IDLE = 1'b1;         // Released bus line level
  localparam logic SDA_DRIVE_LVL = 1'b0;     // Level driven when enabled

  // ----------------------------------------------------------------
  // Timing, link clock domain
  // ----------------------------------------------------------------
  localparam int LINK_PERIOD_NS = 32;        // Link clock period
  localparam int FILTER_MIN_NS = 250;        // Least noise filter time
  localparam int HOLD_NS = 300;              // Undefined SCL fall region
  localparam int FILT_CYC =
    (FILTER_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int FILT_CNT_W = 4;             // Filter counter width
  localparam int HOLD_CYC = (HOLD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam logic [3:0] HOLD_LOAD = 4'(HOLD_CYC - 1);

  // ----------------------------------------------------------------
  // Protocol states, Gray coded along the write path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV = 3'h1,
    ST_WORD = 3'h3,
    ST_WR = 3'h2,
    ST_RD = 3'h6,
    ST_IGNORE = 3'h7
  } tws_state_t;

endpackage

// *** core/tws_sync3.sv ***
// Three-stage synchroniser that settles when stages two and three agree
`timescale 1ns/100ps
module tws_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_in,          // Destination clock
  input wire logic [W-1:0] d_in,    // Level from another domain
  output logic [W-1:0] q_out        // Settled level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } tws_sync_t;

  tws_sync_t r_q;
  tws_sync_t r_d;

  // Shift chain; each output bit follows only when two stages agree
  always_comb begin
    r_d = r_q;
    r_d.s1 = d_in;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    r_d.q = (~(r_q.s2 ^ r_q.s3) & r_q.s3) | ((r_q.s2 ^ r_q.s3) & r_q.q);
  end

  // Register stage
  always_ff @(posedge clk_in) begin
    r_q <= r_d;
  end

  assign q_out = r_q.q;

endmodule // tws_sync3

// *** core/tws_glitch.sv ***
// Noise filter: output follows input only after it stays stable long enough
`timescale 1ns/100ps
module tws_glitch #(
  parameter int STABLE_CYC = 8,
  parameter int CNT_W = 4
) (
  input wire logic clk_in,          // Link clock
  input wire logic rst_in,          // Synchronous reset, active high
  input wire logic d_in,            // Synchronised line level
  output logic q_out                // Filtered line level
);

  typedef struct packed {
    logic q;
    logic [CNT_W-1:0] cnt;
  } tws_glitch_t;

  tws_glitch_t r_q;
  tws_glitch_t r_d;

  // Count consecutive differing samples; a short pulse restarts the count
  always_comb begin
    r_d = r_q;
    if (d_in == r_q.q) begin
      r_d.cnt = '0;
    end else if (r_q.cnt == CNT_W'(STABLE_CYC - 1)) begin
      r_d.q = d_in;
      r_d.cnt = '0;
    end else begin
      r_d.cnt = r_q.cnt + 1'b1;
    end
  end

  // Register stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r_q.q <= tws_pkg::LINE_IDLE;
      r_q.cnt <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q_out = r_q.q;

endmodule // tws_glitch

// *** core/tws_slave.sv ***
// Two-wire slave with word pointer, 64-byte store and power-fail lockout
`timescale 1ns/100ps

module tws_slave (
  input wire logic CLOCK_IN,        // System clock, 200 MHz
  input wire logic SRST_IN,         // Synchronous reset, active high
  input wire logic LINK_CLK_IN,     // Link sampling clock
  input wire logic SCL_IN,          // Bus clock pin level
  input wire logic SDA_IN,          // Bus data pin level
  input wire logic POWER_OK_IN,     // High: supply above deselect level
  output logic SDA_OUT,             // Data pin drive value, always low
  output logic SDA_OE_OUT,          // High while pulling data line low
  output logic WR_VALID_OUT,        // One-cycle pulse per stored byte
  output logic [5:0] WR_ADDR_OUT,   // Location of the stored byte
  output logic [7:0] WR_DATA_OUT,   // Value of the stored byte
  output logic DESELECT_OUT         // High while power-fail lockout
);

  // ----------------------------------------------------------------
  // State records
  // ----------------------------------------------------------------
  typedef struct packed {
    tws_pkg::tws_state_t st;
    logic [3:0] bitc;
    logic [7:0] shr;
    logic [7:0] txb;
    logic [tws_pkg::PTR_W-1:0] ptr;
    logic ack_seen;
    logic pend;
    logic [3:0] hold;
    logic scl_p;
    logic sda_p;
    logic sda_oe;
    logic sda_o;
    logic note_tgl;
    logic [tws_pkg::PTR_W-1:0] note_addr;
    logic [7:0] note_data;
    logic [tws_pkg::MEM_BYTES-1:0][7:0] mem;
  } tws_link_t;

  typedef struct packed {
    logic ack;
    logic vld;
    logic [tws_pkg::PTR_W-1:0] addr;
    logic [7:0] data;
    logic pok1;
    logic pok2;
    logic desel;
  } tws_core_t;

  tws_link_t lr_q;
  tws_link_t lr_d;
  tws_core_t cr_q;
  tws_core_t cr_d;

  logic link_rst;
  logic pwr_ok;
  logic scl_s;
  logic sda_s;
  logic scl_f;
  logic sda_f;
  logic ack_l;
  logic req_c;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Open-drain drive for one transmitted bit, most significant first
  function automatic logic pull_low(logic [7:0] b, logic [3:0] idx);
    return ~b[3'(tws_pkg::BIT_LAST - idx)];
  endfunction

  // Next pointer value; six bits wrap from the top back to zero
  function automatic logic [5:0] ptr_next(logic [5:0] p);
    return p + tws_pkg::PTR_STEP;
  endfunction

  // ----------------------------------------------------------------
  // Crossings into the link domain
  // ----------------------------------------------------------------
  // Reset, supply sense and both bus pins through three stages
  tws_sync3 #(
    .W(4)
  ) u_pin_sync (
    .clk_in(LINK_CLK_IN),
    .d_in({SRST_IN, POWER_OK_IN, SCL_IN, SDA_IN}),
    .q_out({link_rst, pwr_ok, scl_s, sda_s})
  );

  // Acknowledge toggle returned by the system domain
  tws_sync3 #(
    .W(1)
  ) u_ack_sync (
    .clk_in(LINK_CLK_IN),
    .d_in(cr_q.ack),
    .q_out(ack_l)
  );

  // Glitch filters on clock and data lines
  tws_glitch #(
    .STABLE_CYC(tws_pkg::FILT_CYC),
    .CNT_W(tws_pkg::FILT_CNT_W)
  ) u_scl_filt (
    .clk_in(LINK_CLK_IN),
    .rst_in(link_rst),
    .d_in(scl_s),
    .q_out(scl_f)
  );

  tws_glitch #(
    .STABLE_CYC(tws_pkg::FILT_CYC),
    .CNT_W(tws_pkg::FILT_CNT_W)
  ) u_sda_filt (
    .clk_in(LINK_CLK_IN),
    .rst_in(link_rst),
    .d_in(sda_s),
    .q_out(sda_f)
  );

  // ----------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------
  // Data edges while clock stays high are conditions, not data
  assign scl_rise = scl_f & ~lr_q.scl_p;
  assign scl_fall = ~scl_f & lr_q.scl_p;
  assign start_ev = scl_f & lr_q.scl_p & lr_q.sda_p & ~sda_f;
  assign stop_ev = scl_f & lr_q.scl_p & ~lr_q.sda_p & sda_f;

  // ----------------------------------------------------------------
  // Link-side protocol engine
  // ----------------------------------------------------------------
  // Bits are taken on clock rise; actions run a hold time after the fall
  always_comb begin
    lr_d = lr_q;
    lr_d.scl_p = scl_f;
    lr_d.sda_p = sda_f;
    if (!pwr_ok) begin
      // Supply low: drop any access, clear pointer, stay deaf
      lr_d.st = tws_pkg::ST_IDLE;
      lr_d.ptr = tws_pkg::PTR_RST;
      lr_d.bitc = tws_pkg::BIT_FIRST;
      lr_d.pend = 1'b0;
      lr_d.sda_oe = 1'b0;
    end else if (start_ev) begin
      // START from any state, also repeated START
      lr_d.st = tws_pkg::ST_DEV;
      // The START's own clock fall brings the count to the first bit
      lr_d.bitc = tws_pkg::BIT_FIRST - 4'h1;
      lr_d.pend = 1'b0;
      lr_d.sda_oe = 1'b0;
    end else if (stop_ev) begin
      // STOP ends the transfer and frees the bus
      lr_d.st = tws_pkg::ST_IDLE;
      lr_d.pend = 1'b0;
      lr_d.sda_oe = 1'b0;
    end else begin
      // Sample data or master acknowledge on clock rise
      if (scl_rise && lr_q.bitc != tws_pkg::BIT_ACK) begin
        lr_d.shr = {lr_q.shr[6:0], sda_f};
      end
      if (scl_rise && lr_q.bitc == tws_pkg::BIT_ACK) begin
        lr_d.ack_seen = ~sda_f;
      end
      // Idle and ignoring states only watch for START
      if (scl_fall && lr_q.st != tws_pkg::ST_IDLE &&
          lr_q.st != tws_pkg::ST_IGNORE) begin
        lr_d.pend = 1'b1;
        lr_d.hold = tws_pkg::HOLD_LOAD;
      end else if (lr_q.pend && lr_q.hold != 4'h0) begin
        lr_d.hold = lr_q.hold - 4'h1;
      end else if (lr_q.pend) begin
        lr_d.pend = 1'b0;
        if (lr_q.bitc == tws_pkg::BIT_ACK) begin
          // Acknowledge slot over: release and move to next byte
          lr_d.bitc = tws_pkg::BIT_FIRST;
          lr_d.sda_oe = 1'b0;
          unique case (lr_q.st)
            tws_pkg::ST_DEV: begin
              if (lr_q.shr[0]) begin
                lr_d.st = tws_pkg::ST_RD;
                lr_d.txb = lr_q.mem[lr_q.ptr];
                lr_d.sda_oe = pull_low(lr_q.mem[lr_q.ptr],
                                       tws_pkg::BIT_FIRST);
              end else begin
                lr_d.st = tws_pkg::ST_WORD;
              end
            end
            tws_pkg::ST_WORD: begin
              lr_d.ptr = lr_q.shr[5:0];
              lr_d.st = tws_pkg::ST_WR;
            end
            tws_pkg::ST_WR: begin
              lr_d.ptr = ptr_next(lr_q.ptr);
            end
            tws_pkg::ST_RD: begin
              if (lr_q.ack_seen) begin
                lr_d.ptr = ptr_next(lr_q.ptr);
                lr_d.txb = lr_q.mem[ptr_next(lr_q.ptr)];
                lr_d.sda_oe = pull_low(lr_q.mem[ptr_next(lr_q.ptr)],
                                       tws_pkg::BIT_FIRST);
              end else begin
                lr_d.st = tws_pkg::ST_IGNORE;
              end
            end
            default: begin
              lr_d.st = tws_pkg::ST_IGNORE;
            end
          endcase
        end else if (lr_q.bitc == tws_pkg::BIT_LAST) begin
          // Eighth bit done: decide the acknowledge slot
          lr_d.bitc = tws_pkg::BIT_ACK;
          unique case (lr_q.st)
            tws_pkg::ST_DEV: begin
              if (lr_q.shr[7:1] == tws_pkg::SLAVE_ADDR) begin
                lr_d.sda_oe = 1'b1;
              end else begin
                lr_d.st = tws_pkg::ST_IGNORE;
                lr_d.sda_oe = 1'b0;
              end
            end
            tws_pkg::ST_WORD: begin
              lr_d.sda_oe = 1'b1;
            end
            tws_pkg::ST_WR: begin
              lr_d.sda_oe = 1'b1;
              lr_d.mem[lr_q.ptr] = lr_q.shr;
              if (lr_q.note_tgl == ack_l) begin
                lr_d.note_addr = lr_q.ptr;
                lr_d.note_data = lr_q.shr;
                lr_d.note_tgl = ~lr_q.note_tgl;
              end
            end
            tws_pkg::ST_RD: begin
              lr_d.sda_oe = 1'b0;
            end
            default: begin
              lr_d.sda_oe = 1'b0;
            end
          endcase
        end else begin
          // Next data bit; a transmitter presents it only now
          lr_d.bitc = lr_q.bitc + 4'h1;
          if (lr_q.st == tws_pkg::ST_RD) begin
            lr_d.sda_oe = pull_low(lr_q.txb, lr_q.bitc + 4'h1);
          end
        end
      end
    end
  end

  // Link domain registers; acknowledge drive held until after clock fall
  always_ff @(posedge LINK_CLK_IN) begin
    if (link_rst) begin
      lr_q <= '0;
      lr_q.st <= tws_pkg::ST_IDLE;
      lr_q.ptr <= tws_pkg::PTR_RST;
      lr_q.scl_p <= tws_pkg::LINE_IDLE;
      lr_q.sda_p <= tws_pkg::LINE_IDLE;
      lr_q.sda_o <= tws_pkg::SDA_DRIVE_LVL;
    end else begin
      lr_q <= lr_d;
    end
  end

  // ----------------------------------------------------------------
  // System domain: store notifications and lockout status
  // ----------------------------------------------------------------
  tws_sync3 #(
    .W(1)
  ) u_req_sync (
    .clk_in(CLOCK_IN),
    .d_in(lr_q.note_tgl),
    .q_out(req_c)
  );

  // Take a held notification once its toggle arrives, then answer it
  always_comb begin
    cr_d = cr_q;
    cr_d.vld = 1'b0;
    cr_d.pok1 = pwr_ok;
    cr_d.pok2 = cr_q.pok1;
    cr_d.desel = ~cr_q.pok2;
    if (req_c != cr_q.ack) begin
      cr_d.ack = req_c;
      cr_d.vld = 1'b1;
      cr_d.addr = lr_q.note_addr;
      cr_d.data = lr_q.note_data;
    end
  end

  // System domain registers
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      cr_q <= '0;
      // Supply taken as good so the lockout flag does not pulse
      cr_q.pok1 <= 1'b1;
      cr_q.pok2 <= 1'b1;
    end else begin
      cr_q <= cr_d;
    end
  end

  // Outputs straight from flip-flops
  assign SDA_OUT = lr_q.sda_o;
  assign SDA_OE_OUT = lr_q.sda_oe;
  assign WR_VALID_OUT = cr_q.vld;
  assign WR_ADDR_OUT = cr_q.addr;
  assign WR_DATA_OUT = cr_q.data;
  assign DESELECT_OUT = cr_q.desel;

endmodule // tws_slave

// *** testbench/tws_slave_assertions.sv ***
// Port-level checks for the two-wire slave
`timescale 1ns/100ps
module tws_slave_assertions (
  input wire logic CLOCK_IN,          // System clock
  input wire logic SRST_IN,           // Synchronous reset
  input wire logic LINK_CLK_IN,       // Link clock
  input wire logic SCL_IN,            // Bus clock pin
  input wire logic POWER_OK_IN,       // Supply good
  input wire logic SDA_OE_OUT,        // Data pull-down enable
  input wire logic WR_VALID_OUT,      // Store pulse
  input wire logic [5:0] WR_ADDR_OUT, // Store location
  input wire logic [7:0] WR_DATA_OUT, // Store value
  input wire logic DESELECT_OUT       // Lockout flag
);
  // ------------------------------------------------------------------
  // System clock domain
  // ------------------------------------------------------------------
  // Cycles of unchanged supply level; the flag trails the link crossing
  localparam logic [5:0] LAG_CYC = 6'h30;
  logic [5:0] low_run;
  logic [5:0] high_run;
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN || POWER_OK_IN) begin
      low_run <= 6'h00;
    end else if (low_run != LAG_CYC) begin
      low_run <= low_run + 6'h01;
    end
  end
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN || !POWER_OK_IN) begin
      high_run <= 6'h00;
    end else if (high_run != LAG_CYC) begin
      high_run <= high_run + 6'h01;
    end
  end
  lockout_entry_a: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN) low_run == LAG_CYC |-> DESELECT_OUT)
    else $error("lockout flag missing after supply loss");
  lockout_exit_a: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN) high_run == LAG_CYC |-> !DESELECT_OUT)
    else $error("lockout flag stuck with supply good");
  locked_no_store_a: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN) DESELECT_OUT |-> !WR_VALID_OUT)
    else $error("byte stored during lockout");
  store_pulse_a: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN) WR_VALID_OUT |=> !WR_VALID_OUT)
    else $error("store pulse longer than one cycle");
  store_hold_a: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    !WR_VALID_OUT |-> $stable(WR_ADDR_OUT) && $stable(WR_DATA_OUT))
    else $error("store location or value moved without pulse");
  // ------------------------------------------------------------------
  // Link clock domain
  // ------------------------------------------------------------------
  lockout_quiet_a: assert property (@(posedge LINK_CLK_IN)
    disable iff (SRST_IN) !POWER_OK_IN [*8] |-> !SDA_OE_OUT)
    else $error("data line driven during lockout");
  ack_edge_low_a: assert property (@(posedge LINK_CLK_IN)
    disable iff (SRST_IN) $changed(SDA_OE_OUT) && POWER_OK_IN |-> !SCL_IN)
    else $error("data drive changed while clock high");
  ack_span_a: assert property (@(posedge LINK_CLK_IN)
    disable iff (SRST_IN)
    $rose(SDA_OE_OUT) |-> SDA_OE_OUT [*8] ##[1:1000] !SDA_OE_OUT)
    else $error("acknowledge drive not one clock slot");
  ack_steady_a: assert property (@(posedge LINK_CLK_IN)
    disable iff (SRST_IN)
    SDA_OE_OUT && SCL_IN |=> SDA_OE_OUT || !SCL_IN)
    else $error("acknowledge dropped during clock high");
  // Main scenarios reached
  cover property (@(posedge CLOCK_IN) WR_VALID_OUT);
  cover property (@(posedge CLOCK_IN) $rose(DESELECT_OUT));
  cover property (@(posedge LINK_CLK_IN) $rose(SDA_OE_OUT));
endmodule // tws_slave_assertions

bind tws_slave tws_slave_assertions tws_slave_assertions_inst (
  .CLOCK_IN(CLOCK_IN), .SRST_IN(SRST_IN), .LINK_CLK_IN(LINK_CLK_IN),
  .SCL_IN(SCL_IN), .POWER_OK_IN(POWER_OK_IN), .SDA_OE_OUT(SDA_OE_OUT),
  .WR_VALID_OUT(WR_VALID_OUT), .WR_ADDR_OUT(WR_ADDR_OUT),
  .WR_DATA_OUT(WR_DATA_OUT), .DESELECT_OUT(DESELECT_OUT)
);

// *** testbench/tws_master.sv ***
// Bus master model driving the two-wire clock and data lines
`timescale 1ns/100ps
module tws_master (
  input wire logic sda_in,  // Resolved data line
  output logic scl_out,     // Clock line, high when released
  output logic sda_rel_out  // High: master releases data line
);
  // ------------------------------------------------------------------
  // Timing, changeable for a slow master
  // ------------------------------------------------------------------
  int t_low = 1600;  // Clock low time in ns
  int t_high = 1000; // Clock high time in ns
  // Idle bus at start
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end
  // One clock: data set mid-low, sampled mid-high, optional short glitch
  task automatic clock_bit(input logic b, input bit gl, output logic s);
    #(t_low / 2);
    sda_rel_out = b;
    #(t_low / 2);
    scl_out = 1'b1;
    #(t_high / 2);
    s = sda_in;
    if (gl) begin
      scl_out = 1'b0;
      #100;
      scl_out = 1'b1;
    end
    #(t_high / 2);
    scl_out = 1'b0;
  endtask
  // START: data falls while clock high
  task automatic bus_start();
    #(t_low / 2);
    sda_rel_out = 1'b1;
    #(t_low / 2);
    scl_out = 1'b1;
    #(t_high);
    sda_rel_out = 1'b0;
    #(t_high);
    scl_out = 1'b0;
  endtask
  // STOP: data rises while clock high, then bus free time
  task automatic bus_stop();
    #(t_low / 2);
    sda_rel_out = 1'b0;
    #(t_low / 2);
    scl_out = 1'b1;
    #(t_high);
    sda_rel_out = 1'b1;
    #(t_low);
  endtask
  // Top n bits MSB first; a whole byte gets the acknowledge clock
  task automatic send_byte(input logic [7:0] v, input int n, input bit gl,
                           output logic ack);
    logic s;
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--)
      clock_bit(v[i], gl, s);
    if (n == 8) begin
      clock_bit(1'b1, 1'b0, s);
      ack = ~s;
    end
  endtask
  // Eight bits from the slave, then acknowledge (ack high) or withhold it
  task automatic recv_byte(input logic ack, output logic [7:0] v,
                           output logic line9);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, 1'b0, s);
      v[i] = s;
    end
    clock_bit(~ack, 1'b0, line9);
  endtask
endmodule // tws_master

// *** testbench/tb_top.sv ***
// Self-checking bench for the two-wire slave write path and lockout
`timescale 1ns/100ps
module tb_top;
  // ------------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------------
  localparam int RST_CYC = 60;
  localparam int TIMEOUT_CYC = 90000;
  logic clk;
  logic link_clk;
  logic srst = 1'b1;
  logic power_ok = 1'b1;
  logic scl;
  logic sda_rel;
  logic sda_drv;
  logic sda_oe;
  logic wr_valid;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic deselect;
  wire sda_line = sda_oe ? (sda_rel & sda_drv) : sda_rel; // Pull-up
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int ptr = 0;
  logic [13:0] exp_q[$];
  logic [7:0] model [64] = '{default: 8'h00};
  logic [31:0] seed = 32'h4D77155A;

  tws_slave tws_slave_inst (
    .CLOCK_IN(clk), .SRST_IN(srst), .LINK_CLK_IN(link_clk), .SCL_IN(scl),
    .SDA_IN(sda_line), .POWER_OK_IN(power_ok), .SDA_OUT(sda_drv),
    .SDA_OE_OUT(sda_oe), .WR_VALID_OUT(wr_valid), .WR_ADDR_OUT(wr_addr),
    .WR_DATA_OUT(wr_data), .DESELECT_OUT(deselect)
  );
  tws_master tws_master_inst (
    .sda_in(sda_line), .scl_out(scl), .sda_rel_out(sda_rel)
  );

  // ------------------------------------------------------------------
  // Clocks, timeout and store monitor
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Link clock, unrelated in phase
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #16 link_clk = ~link_clk;
  end
  // Cuts a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYC) begin
      num_errors++;
      $display("CHECK FAILED %0t ns: timeout", $time);
      complete_run();
    end
  end
  // Each stored byte against the model's oldest expectation
  always @(posedge clk) begin
    if (!srst && wr_valid === 1'b1) begin
      check(exp_q.size() > 0, "unexpected store");
      if (exp_q.size() > 0) begin
        check({wr_addr, wr_data} === exp_q[0], "store");
        void'(exp_q.pop_front());
      end
    end
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED %0t ns: %s", $time, msg);
    end
  endtask
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic put_byte(input logic [7:0] v, input bit gl,
                          input logic want);
    logic ack;
    tws_master_inst.send_byte(v, 8, gl, ack);
    check(ack === want, "acknowledge bit");
  endtask
  // Whole write: slave address, word address, n random data bytes
  task automatic write_seq(input logic [7:0] word, input int n,
                           input bit gl);
    logic [7:0] v;
    tws_master_inst.bus_start();
    put_byte({tws_pkg::SLAVE_ADDR, 1'b0}, 1'b0, 1'b1);
    put_byte(word, 1'b0, 1'b1);
    ptr = int'(word) % 64;
    for (int i = 0; i < n; i++) begin
      v = 8'(xorshift());
      exp_q.push_back({ptr[5:0], v});
      model[ptr] = v;
      put_byte(v, gl, 1'b1);
      ptr = (ptr + 1) % 64;
    end
    tws_master_inst.bus_stop();
  endtask
  task automatic end_test(input string name);
    tick(50);
    check(exp_q.size() == 0, "missing store");
    $display("Test %s finished", name);
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [6:0] bad;
    logic ack;
    logic [7:0] rd;
    logic s9;
    tick(RST_CYC);
    srst = 1'b0;
    tick(100);
    // Wrapping pointer, top word bits ignored, glitches filtered
    write_seq(8'hFF, 2, 1'b1);
    end_test("wrap");
    // Foreign address from a slow master
    bad = 7'(xorshift());
    if (bad == tws_pkg::SLAVE_ADDR)
      bad = bad ^ 7'h01;
    tws_master_inst.t_low = 3200;
    tws_master_inst.bus_start();
    put_byte({bad, 1'b0}, 1'b0, 1'b0);
    tws_master_inst.bus_stop();
    tws_master_inst.t_low = 1600;
    end_test("foreign address");
    // Supply loss in mid-byte, traffic during lockout, then recovery
    tws_master_inst.bus_start();
    put_byte({tws_pkg::SLAVE_ADDR, 1'b0}, 1'b0, 1'b1);
    put_byte(8'h05, 1'b0, 1'b1);
    tws_master_inst.send_byte(8'hA5, 3, 1'b0, ack);
    tick(1);
    power_ok = 1'b0;
    tick(60);
    check(deselect === 1'b1, "lockout flag");
    tws_master_inst.bus_start();
    put_byte({tws_pkg::SLAVE_ADDR, 1'b0}, 1'b0, 1'b0);
    tws_master_inst.bus_stop();
    tick(1);
    power_ok = 1'b1;
    tick(400);
    check(deselect === 1'b0, "lockout release");
    // Read from the cleared pointer: acknowledged byte, then last byte
    tws_master_inst.bus_start();
    put_byte({tws_pkg::SLAVE_ADDR, 1'b1}, 1'b0, 1'b1);
    tws_master_inst.recv_byte(1'b1, rd, s9);
    check(rd === model[0], "read after lockout");
    tws_master_inst.recv_byte(1'b0, rd, s9);
    check(rd === model[1], "read after acknowledge");
    check(s9 === 1'b1, "line released after last byte");
    tws_master_inst.bus_stop();
    write_seq(8'h12, 1, 1'b0);
    end_test("power fail");
    complete_run();
  end
endmodule // tb_top
